//--- logic/coc_codec.sv
`timescale 1ns/1ps
`default_nettype none
`include "coc_consts.svh"

// Functional notes
// - two config sets: K28.5 then D21.5, or K28.5 then D2.2, plus two data groups.
// - third group carries word bits 7..0, fourth carries bits 15..8.
// - on the line the low byte goes first, then the high byte.
// - reserved bits of the sent base page are always zero.
// - sent base page has full duplex, half duplex, or both set.
// - ack starts zero, sets after three identical non-zero received words.
// - sent config sets alternate strictly between first and second type.
// - after restart only four-group config sets are sent.
// - low byte ?HF00000, high byte ?A??000?, ack at bit 14.
// - valid received set starts K28.5 then D21.5 or D2.2, four groups.
// - invalid groups received in config mode restart negotiation.
// - idle pattern K28.5, other data group, K28.5 again is accepted.
// - any other pattern in config mode is invalid and restarts.
// - running disparity errors, wrong-polarity K28.5 included, are invalid and restart.
// - restart sends all-zero word; steady invalid input keeps it zero.
// - a stream of only one set type still decodes and sets ack.
module coc_codec
  import coc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxIsK,
  input  wire logic        rxDispErr,
  input  wire logic        rxCodeErr,
  output logic      [7:0]  txData,
  output logic             txIsK,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq
);

  logic                cfgEn_reg;
  logic [15:0]         adv_reg;
  logic [2:0]          irqStat_reg;
  logic [2:0]          irqMask_reg;
  logic [1:0]          txSlot_reg;
  logic [1:0]          txPhase_reg;
  logic                txMode_reg;
  logic                txAlt_reg;
  logic [15:0]         txCfg_reg;
  logic [3:0]          zeroCnt_reg;
  coc_rx_t             rxState_reg;
  coc_rx_t             rxState_next;
  logic [7:0]          rxLow_reg;
  logic [15:0]         lastCfg_reg;
  logic [1:0]          matchCnt_reg;
  logic [1:0]          matchCnt_next;
  logic                ack_reg;
  logic                wbHit;
  logic                wbWr;
  logic [7:0]          adrOff;
  logic                swRestart;
  logic                rxBad;
  logic                cfgDone;
  logic                kStart;
  logic                restartNow;
  logic                ackRise;
  logic [15:0]         newCfg;
  logic [15:0]         advTx;
  logic [15:0]         advWr;
  logic [2:0]          irqEv;
  logic [2:0]          irqClr;
  logic [31:0]         rdData;

  // bus decode
  assign wbHit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr      = wbHit & wb_we_i;
  assign adrOff    = {wb_adr_i[7:2], 2'b00};
  assign swRestart = wbWr & (adrOff == `COC_OFF_CTRL) & wb_sel_i[0]
                   & wb_dat_i[`COC_CTRL_RESTART];

  // receive parser, one code group per valid cycle
  assign kStart = rxIsK & (rxData == `COC_K28_5);
  always_comb
  begin
    rxState_next = rxState_reg;
    rxBad        = 1'b0;
    cfgDone      = 1'b0;
    if (rxValid)
    begin
      case (rxState_reg)
        RX_EXPK:
        begin
          if (kStart)
            rxState_next = RX_SECOND;
          else
            rxBad = 1'b1;
        end
        RX_SECOND:
        begin
          if (rxIsK)
          begin
            rxBad        = 1'b1;
            rxState_next = kStart ? RX_SECOND : RX_EXPK;
          end
          else if ((rxData == `COC_D21_5) || (rxData == `COC_D2_2))
            rxState_next = RX_LOW;
          else
            rxState_next = RX_EXPK;
        end
        RX_LOW, RX_HIGH:
        begin
          if (rxIsK)
          begin
            rxBad        = 1'b1;
            rxState_next = kStart ? RX_SECOND : RX_EXPK;
          end
          else if (rxState_reg == RX_LOW)
            rxState_next = RX_HIGH;
          else
          begin
            rxState_next = RX_EXPK;
            cfgDone      = 1'b1;
          end
        end
        default:
          rxState_next = RX_EXPK;
      endcase
      if (rxDispErr | rxCodeErr)
      begin
        rxBad        = 1'b1;
        rxState_next = RX_EXPK;
        cfgDone      = 1'b0;
      end
    end
  end

  assign restartNow = swRestart | (cfgEn_reg & rxBad);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rxState_reg <= RX_EXPK;
    else
      rxState_reg <= rxState_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rxLow_reg <= 8'h00;
    else if (rxValid && (rxState_reg == RX_LOW) && !rxIsK)
      rxLow_reg <= rxData;
  end

  // ability match and acknowledge
  assign newCfg = {rxData, rxLow_reg};
  always_comb
  begin
    if (newCfg == 16'h0000)
      matchCnt_next = 2'd0;
    else if (newCfg == lastCfg_reg)
      matchCnt_next = (matchCnt_reg == 2'd3) ? 2'd3 : matchCnt_reg + 2'd1;
    else
      matchCnt_next = 2'd1;
  end
  assign ackRise = cfgDone & ~restartNow & (matchCnt_next == 2'd3) & ~ack_reg;

  always_ff @(posedge clk)
  begin
    if (!rstn || restartNow)
    begin
      matchCnt_reg <= 2'd0;
      lastCfg_reg  <= 16'h0000;
      ack_reg      <= 1'b0;
    end
    else if (cfgDone)
    begin
      matchCnt_reg <= matchCnt_next;
      lastCfg_reg  <= newCfg;
      if (matchCnt_next == 2'd3)
        ack_reg <= 1'b1;
    end
  end

  // transmit word build
  always_comb
  begin
    advTx = adv_reg & `COC_ADV_WMASK;
    if (!advTx[`COC_BIT_HD] && !advTx[`COC_BIT_FD])
      advTx[`COC_BIT_FD] = 1'b1;
    advTx[`COC_BIT_ACK] = ack_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || restartNow)
      zeroCnt_reg <= `COC_RESTART_SETS;
    else if ((txSlot_reg == 2'd0) && (zeroCnt_reg != 4'h0))
      zeroCnt_reg <= zeroCnt_reg - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      txCfg_reg  <= 16'h0000;
      txMode_reg <= 1'b0;
    end
    else if (txSlot_reg == 2'd0)
    begin
      txMode_reg <= cfgEn_reg | swRestart;
      if ((zeroCnt_reg != 4'h0) || restartNow)
        txCfg_reg <= 16'h0000;
      else
        txCfg_reg <= advTx;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      txSlot_reg  <= 2'd0;
      txPhase_reg <= 2'd0;
    end
    else
    begin
      txSlot_reg  <= txSlot_reg + 2'd1;
      txPhase_reg <= txSlot_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      txAlt_reg <= 1'b0;
    else if ((txSlot_reg == 2'd1) && txMode_reg)
      txAlt_reg <= ~txAlt_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      txData <= `COC_K28_5;
      txIsK  <= 1'b1;
    end
    else
    begin
      case (txSlot_reg)
        2'd0:
        begin
          txData <= `COC_K28_5;
          txIsK  <= 1'b1;
        end
        2'd1:
        begin
          txIsK <= 1'b0;
          if (!txMode_reg)
            txData <= `COC_D16_2;
          else
            txData <= txAlt_reg ? `COC_D2_2 : `COC_D21_5;
        end
        2'd2:
        begin
          txData <= txMode_reg ? txCfg_reg[7:0] : `COC_K28_5;
          txIsK  <= ~txMode_reg;
        end
        default:
        begin
          txData <= txMode_reg ? txCfg_reg[15:8] : `COC_D16_2;
          txIsK  <= 1'b0;
        end
      endcase
    end
  end

  // software registers
  assign advWr = wb_dat_i[15:0] & `COC_ADV_WMASK;
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cfgEn_reg <= `COC_CTRL_CFG_RESET;
    else if (swRestart)
      cfgEn_reg <= 1'b1;
    else if (wbWr && (adrOff == `COC_OFF_CTRL) && wb_sel_i[0])
      cfgEn_reg <= wb_dat_i[`COC_CTRL_CFGEN];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      adv_reg <= `COC_ADV_RESET;
    else if (wbWr && (adrOff == `COC_OFF_ADV))
    begin
      if (wb_sel_i[0])
        adv_reg[7:0] <= advWr[7:0];
      if (wb_sel_i[1])
        adv_reg[15:8] <= advWr[15:8];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irqMask_reg <= 3'b000;
    else if (wbWr && (adrOff == `COC_OFF_IRQMSK) && wb_sel_i[0])
      irqMask_reg <= wb_dat_i[2:0];
  end

  // sticky events, set wins over write-one-clear
  assign irqEv[`COC_IRQ_RESTART] = restartNow;
  assign irqEv[`COC_IRQ_PAGE]    = cfgDone & ~restartNow;
  assign irqEv[`COC_IRQ_ACK]     = ackRise;
  assign irqClr = (wbWr && (adrOff == `COC_OFF_IRQST) && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'b000;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      irqStat_reg <= 3'b000;
      irq         <= 1'b0;
    end
    else
    begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqEv;
      irq         <= |(irqStat_reg & irqMask_reg);
    end
  end

  always_comb
  begin
    case (adrOff)
      `COC_OFF_CTRL:   rdData = {31'h00000000, cfgEn_reg};
      `COC_OFF_ADV:    rdData = {16'h0000, adv_reg};
      `COC_OFF_STATUS: rdData = {txCfg_reg, 12'h000, (zeroCnt_reg != 4'h0), matchCnt_reg, ack_reg};
      `COC_OFF_RXCFG:  rdData = {16'h0000, lastCfg_reg};
      `COC_OFF_IRQST:  rdData = {29'h00000000, irqStat_reg};
      `COC_OFF_IRQMSK: rdData = {29'h00000000, irqMask_reg};
      default:         rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wbHit;
      wb_dat_o <= (wbHit && !wb_we_i) ? rdData : 32'h00000000;
    end
  end

  // checks
  sequence s_cfgLead;
    (txPhase_reg == 2'd0 && txIsK && txData == `COC_K28_5)
    ##1 (!txIsK && (txData == `COC_D21_5 || txData == `COC_D2_2));
  endsequence

  sequence s_idle;
    (rxValid && kStart && !rxDispErr && !rxCodeErr)
    ##1 (rxValid && !rxIsK && rxData != `COC_D21_5 && rxData != `COC_D2_2
         && !rxDispErr && !rxCodeErr);
  endsequence

  a_tx_lead_codes: assert property (@(posedge clk) disable iff (!rstn)
    (txPhase_reg == 2'd0 && txMode_reg) |-> s_cfgLead)
    else $error("config set does not open with K28.5 and a set code");

  a_tx_alternate: assert property (@(posedge clk) disable iff (!rstn)
    (txPhase_reg == 2'd1 && txMode_reg) ##4 txMode_reg |-> txData != $past(txData, 4))
    else $error("config set types did not alternate");

  a_byte_order: assert property (@(posedge clk) disable iff (!rstn)
    (txPhase_reg == 2'd2 && txMode_reg)
    |-> (txData == txCfg_reg[7:0]) ##1 (txData == txCfg_reg[15:8]))
    else $error("config word bytes out of order");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
    (txPhase_reg == 2'd2 && txMode_reg) |-> (txData[4:0] == 5'h00) ##1 (txData[3:1] == 3'h0))
    else $error("reserved bit sent as one");

  a_duplex_set: assert property (@(posedge clk) disable iff (!rstn)
    (txPhase_reg == 2'd2 && txMode_reg && txCfg_reg != 16'h0000) |-> (|txData[6:5]))
    else $error("no duplex ability advertised");

  a_ack_three: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ack_reg) |-> (matchCnt_reg == 2'd3) && $past(cfgDone) && $past(newCfg) == lastCfg_reg)
    else $error("ack set without three matching words");

  a_restart_zero: assert property (@(posedge clk) disable iff (!rstn)
    (restartNow && cfgEn_reg) |-> ##[1:8] (txPhase_reg == 2'd2 && txData == 8'h00))
    else $error("no zero word after restart");

  a_bad_restart: assert property (@(posedge clk) disable iff (!rstn)
    (cfgEn_reg && rxValid && (rxDispErr || rxCodeErr))
    |=> (zeroCnt_reg == `COC_RESTART_SETS) && !ack_reg && (matchCnt_reg == 2'd0))
    else $error("disparity or code error did not restart");

  a_short_set: assert property (@(posedge clk) disable iff (!rstn)
    (cfgEn_reg && rxValid && rxIsK && (rxState_reg == RX_LOW || rxState_reg == RX_HIGH))
    |=> !ack_reg && (matchCnt_reg == 2'd0) && irqStat_reg[`COC_IRQ_RESTART])
    else $error("short config set not treated as invalid");

  a_idle_accept: assert property (@(posedge clk) disable iff (!rstn)
    (rxState_reg == RX_EXPK) ##0 s_idle |-> !rxBad && $past(!rxBad))
    else $error("idle pattern flagged invalid");

  a_cfg_extract: assert property (@(posedge clk) disable iff (!rstn)
    $past(cfgDone && !restartNow) |-> lastCfg_reg == {$past(rxData), $past(rxLow_reg)})
    else $error("received word not extracted");

endmodule
`default_nettype wire

//--- logic/coc_consts.svh
`ifndef COC_CONSTS_SVH
`define COC_CONSTS_SVH

// code-group values (8-bit form, K flag separate)
`define COC_K28_5           8'hBC
`define COC_D21_5           8'hB5
`define COC_D2_2            8'h42
`define COC_D16_2           8'h50

// register byte offsets
`define COC_OFF_CTRL        8'h00
`define COC_OFF_ADV         8'h04
`define COC_OFF_STATUS      8'h08
`define COC_OFF_RXCFG       8'h0C
`define COC_OFF_IRQST       8'h10
`define COC_OFF_IRQMSK      8'h14

// control fields
`define COC_CTRL_CFGEN      0
`define COC_CTRL_RESTART    1
`define COC_CTRL_CFG_RESET  1'b1

// configuration word fields
`define COC_BIT_FD          5
`define COC_BIT_HD          6
`define COC_BIT_ACK         14
`define COC_ADV_WMASK       16'hB1E0
`define COC_ADV_RESET       16'h0020

// code sets of all-zero word sent after a restart
`define COC_RESTART_SETS    4'h8

// interrupt bits
`define COC_IRQ_RESTART     0
`define COC_IRQ_PAGE        1
`define COC_IRQ_ACK         2
`define COC_IRQ_W           3

`endif

//--- logic/coc_pkg.sv
`default_nettype none
package coc_pkg;
  typedef enum logic [1:0] {RX_EXPK, RX_SECOND, RX_LOW, RX_HIGH} coc_rx_t;
endpackage
`default_nettype wire

//--- tb/coc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "coc_consts.svh"
// modes: 0 c1/c2, 1 c1 only, 2 k28.5 d21.5 repeat, 3 disparity error, 4 idle, 5 code error
module coc_link_partner
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] word,
  output logic             rxValid,
  output logic      [7:0]  rxData,
  output logic             rxIsK,
  output logic             rxDispErr,
  output logic             rxCodeErr
);
  logic [1:0] slotReg;
  logic       altReg;
  logic       pairMode;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      slotReg <= 2'h0;
      altReg  <= 1'b0;
    end
    else
    begin
      slotReg <= slotReg + 2'h1;
      if (slotReg == 2'h3)
        altReg <= ~altReg;
    end
  end

  assign pairMode = (mode == 3'h2) || (mode == 3'h4);

  always_comb
  begin
    rxValid   = rstn;
    rxIsK     = (slotReg == 2'h0) || (pairMode && slotReg == 2'h2);
    rxDispErr = (mode == 3'h3) && (slotReg == 2'h2);
    rxCodeErr = (mode == 3'h5) && (slotReg == 2'h1);
    if (rxIsK)
      rxData = `COC_K28_5;
    else if (slotReg == 2'h2)
      rxData = word[7:0];
    else if (slotReg == 2'h3 && !pairMode)
      rxData = word[15:8];
    else if (mode == 3'h4)
      rxData = `COC_D16_2;
    else if (altReg && mode != 3'h1 && mode != 3'h2)
      rxData = `COC_D2_2;
    else
      rxData = `COC_D21_5;
  end
endmodule
`default_nettype wire

//--- tb/config_ordered_set_codec_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "coc_consts.svh"
module config_ordered_set_codec_test;
  logic        clk;
  logic        rstn;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        irq;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxIsK;
  logic        rxDispErr;
  logic        rxCodeErr;
  logic [7:0]  txData;
  logic        txIsK;
  logic [2:0]  peerMode;
  logic [15:0] peerWord;
  logic [31:0] rdq;
  logic [15:0] setWord;
  logic        setSecond;
  int          errTotal;
  int          nTests;

  coc_codec uut (.clk(clk), .rstn(rstn), .rxValid(rxValid), .rxData(rxData), .rxIsK(rxIsK),
    .rxDispErr(rxDispErr), .rxCodeErr(rxCodeErr), .txData(txData), .txIsK(txIsK),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq));

  coc_link_partner peer (.clk(clk), .rstn(rstn), .mode(peerMode), .word(peerWord),
    .rxValid(rxValid), .rxData(rxData), .rxIsK(rxIsK), .rxDispErr(rxDispErr),
    .rxCodeErr(rxCodeErr));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task stopTest;
    if (errTotal == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task hang(input string nm);
    chk(nm, 32'h0, 32'h1);
    stopTest();
  endtask

  // classic single cycle, entered just after a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= 4'hF;
    do
    begin
      @(posedge clk);
      i++;
    end while (wbAck !== 1'b1 && i < 16);
    if (wbAck !== 1'b1)
      hang("bus ack wait");
    rdq = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // collect one four-group set from the line
  task getSet;
    int i;
    logic [7:0] g1;
    logic [7:0] g2;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (!(txIsK === 1'b1 && txData === `COC_K28_5) && i < 16);
    if (!(txIsK === 1'b1 && txData === `COC_K28_5))
      hang("tx set start");
    @(posedge clk);
    g1 = txData;
    @(posedge clk);
    g2 = txData;
    @(posedge clk);
    setWord = {txData, g2};
    chk("tx second group", {24'h0, (g1 === `COC_D2_2) ? `COC_D2_2 : `COC_D21_5}, {24'h0, g1});
    setSecond = (g1 === `COC_D2_2);
  endtask

  task sReset;
    getSet();
    chk("first set type", 32'h0, {31'h0, setSecond});
    chk("first set word", 32'h0, {16'h0, setWord});
    getSet();
    chk("second set type", 32'h1, {31'h0, setSecond});
    wb(1'b0, `COC_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rdq);
    wb(1'b0, `COC_OFF_ADV, 32'h0);
    chk("adv reset", 32'h20, rdq);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rdq);
  endtask

  task sAck(input logic [2:0] m, input logic [15:0] adv, input logic [15:0] exp);
    int n;
    logic prev;
    peerWord <= 16'h01A0;
    peerMode <= m;
    wb(1'b1, `COC_OFF_ADV, {16'h0, adv});
    wb(1'b0, `COC_OFF_ADV, 32'h0);
    chk("adv readback", {16'h0, adv & `COC_ADV_WMASK}, rdq);
    wb(1'b1, `COC_OFF_CTRL, 32'h3);
    wb(1'b0, `COC_OFF_STATUS, 32'h0);
    chk("ack after restart", 32'h0, {31'h0, rdq[0]});
    wb(1'b1, `COC_OFF_IRQST, 32'h7);
    wb(1'b1, `COC_OFF_IRQMSK, 32'h4);
    n = 0;
    getSet();
    prev = setSecond;
    while (setWord === 16'h0 && n < 40)
    begin
      getSet();
      chk("set alternation", {31'h0, !prev}, {31'h0, setSecond});
      prev = setSecond;
      n++;
    end
    if (setWord === 16'h0)
      hang("zero word phase");
    chk("tx word", {16'h0, exp}, {16'h0, setWord});
    wb(1'b0, `COC_OFF_RXCFG, 32'h0);
    chk("rx word", 32'h01A0, rdq);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(1'b1, `COC_OFF_IRQST, 32'h4);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task sInvalid(input logic [2:0] m);
    peerMode <= m;
    wb(1'b1, `COC_OFF_CTRL, 32'h3);
    wb(1'b1, `COC_OFF_IRQST, 32'h7);
    repeat (12)
    begin
      getSet();
      chk("word under errors", 32'h0, {16'h0, setWord});
    end
    wb(1'b0, `COC_OFF_IRQST, 32'h0);
    chk("restart flagged", 32'h1, {31'h0, rdq[0]});
    wb(1'b0, `COC_OFF_STATUS, 32'h0);
    chk("no ack under errors", 32'h0, {31'h0, rdq[0]});
  endtask

  task sIdle;
    peerMode <= 3'h4;
    repeat (2)
      getSet();
    wb(1'b1, `COC_OFF_IRQST, 32'h7);
    repeat (10)
      getSet();
    wb(1'b0, `COC_OFF_IRQST, 32'h0);
    chk("idle no restart", 32'h0, {31'h0, rdq[0]});
    chk("idle word", 32'h20, {16'h0, setWord});
  endtask

  initial
  begin
    errTotal = 0;
    nTests = 0;
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    peerMode = 3'h4;
    peerWord = 16'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    sReset();
    sAck(3'h0, 16'hFFFF, 16'hF1E0);
    sAck(3'h1, 16'h0000, 16'h4020);
    sInvalid(3'h2);
    sInvalid(3'h3);
    sInvalid(3'h5);
    sIdle();
    stopTest();
  end
endmodule
`default_nettype wire
